// File: pkg/pfp_pkg.sv
package pfp_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Timing, system clock 10 MHz
   localparam int          CLK_HZ          = 10_000_000;
   localparam int          MID_WIDTH_US    = 15;
   localparam int          TOP_WIDTH_US    = 30;
   localparam int          US_PER_S        = 1_000_000;
   // Least widths round up to whole cycles
   localparam int          MID_MIN_CYC     = (MID_WIDTH_US * CLK_HZ + US_PER_S - 1) / US_PER_S;
   localparam int          TOP_MIN_CYC     = (TOP_WIDTH_US * CLK_HZ + US_PER_S - 1) / US_PER_S;
   localparam int          CNT_W           = 9;
   localparam logic [8:0]  CNT_MID_MIN     = 9'(MID_MIN_CYC);
   localparam logic [8:0]  CNT_TOP_MIN     = 9'(TOP_MIN_CYC);
   localparam logic [8:0]  CNT_SAT         = 9'h1ff;

   ////////////////////////////////////////////////////////////////////////////
   // Keys and codes
   localparam int          KEY_W           = 3;
   localparam logic [2:0]  KEY_ZERO_FIELD  = 3'h1;
   localparam logic [2:0]  KEY_GAIN        = 3'h2;
   localparam logic [2:0]  KEY_MISC        = 3'h3;
   localparam logic [2:0]  KEY_SAT         = 3'h7;
   localparam int          CODE_W          = 6;
   localparam logic [5:0]  ZERO_FIELD_MAX  = 6'h3f;
   localparam logic [5:0]  GAIN_MAX        = 6'h3f;
   localparam logic [5:0]  MISC_MAX        = 6'h10;
   localparam int          MISC_DRIFT_MSB  = 2;
   localparam int          MISC_INVERT_BIT = 3;

   ////////////////////////////////////////////////////////////////////////////
   // Fuse array layout
   localparam int          FUSE_W          = 17;
   localparam int          FUSE_ZF_LSB     = 0;
   localparam int          FUSE_GAIN_LSB   = 6;
   localparam int          FUSE_MISC_LSB   = 12;
   localparam int          FUSE_MISC_W     = 5;
   localparam int          FUSE_SEAL_BIT   = 16;

   ////////////////////////////////////////////////////////////////////////////
   // Wishbone register map
   localparam int          ADR_W           = 8;
   localparam logic [7:0]  ADR_STATUS      = 8'h00;
   localparam logic [7:0]  ADR_TRIM        = 8'h04;
   localparam logic [7:0]  ADR_CTRL        = 8'h08;
   localparam logic [7:0]  ADR_FUSE        = 8'h0c;
   localparam logic [31:0] CTRL_RESET      = 32'h0000_0001;
   localparam int          CTRL_ENABLE_BIT = 0;
   localparam int          ST_STATE_LSB    = 0;
   localparam int          ST_KEY_LSB      = 4;
   localparam int          ST_CODE_LSB     = 8;
   localparam int          ST_SEAL_BIT     = 16;
   localparam int          TR_ZF_LSB       = 0;
   localparam int          TR_GAIN_LSB     = 8;
   localparam int          TR_DRIFT_LSB    = 16;
   localparam int          TR_INVERT_BIT   = 24;

   ////////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [2:0] {
      ST_INIT,
      ST_SELECT,
      ST_ADDRESS,
      ST_BURN,
      ST_DONE
   } pfp_state_type;

   typedef struct packed {
      logic [5:0] zero_field;
      logic [5:0] gain;
      logic [2:0] drift;
      logic       invert;
   } pfp_trim_type;

   typedef struct packed {
      logic mid_done;
      logic top_done;
      logic top_qual;
      logic top_level;
   } pfp_pulse_type;

endpackage

// File: hw/pfp_pulse_classifier.sv
`timescale 1ns/10ps
module pfp_pulse_classifier
(
   input  wire logic                   clk_sys_i,
   input  wire logic                   nrst_i,
   input  wire logic                   mid_cmp_i,
   input  wire logic                   top_cmp_i,
   output pfp_pkg::pfp_pulse_type      pulse_o
);
   import pfp_pkg::*;

   logic [1:0]             sync1_ff;
   logic [1:0]             sync2_ff;
   logic [CNT_W-1:0]       act_cnt_ff;
   logic [CNT_W-1:0]       top_cnt_ff;
   pfp_pulse_type          pulse_ff;
   logic                   lvl_act;
   logic                   lvl_top;
   logic                   falling;

   ////////////////////////////////////////////////////////////////////////////
   // Comparator levels are asynchronous to the clock
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         sync1_ff <= 2'h0;
         sync2_ff <= 2'h0;
      end
      else
      begin
         sync1_ff <= {top_cmp_i, mid_cmp_i};
         sync2_ff <= sync1_ff;
      end
   end

   // Top comparator implies the middle one is above too
   assign lvl_act = sync2_ff[0] | sync2_ff[1];          // RULE1
   assign lvl_top = sync2_ff[1];                        // RULE1
   assign falling = !lvl_act && (act_cnt_ff != 9'h000);

   ////////////////////////////////////////////////////////////////////////////
   // Width counters, saturating so a stuck pin cannot wrap
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         act_cnt_ff <= 9'h000;
         top_cnt_ff <= 9'h000;
      end
      else if (!lvl_act)
      begin
         act_cnt_ff <= 9'h000;
         top_cnt_ff <= 9'h000;
      end
      else
      begin
         if (act_cnt_ff != CNT_SAT)
            act_cnt_ff <= 9'(act_cnt_ff + 9'h001);
         if (lvl_top && (top_cnt_ff != CNT_SAT))
            top_cnt_ff <= 9'(top_cnt_ff + 9'h001);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Events: short pulses are glitches and are dropped
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
         pulse_ff <= '0;
      else
      begin
         pulse_ff.mid_done  <= falling && (act_cnt_ff >= CNT_MID_MIN) && (top_cnt_ff == 9'h000);  // RULE3
         pulse_ff.top_done  <= falling && (top_cnt_ff >= CNT_TOP_MIN);                             // RULE2
         pulse_ff.top_qual  <= lvl_top && (top_cnt_ff == 9'(CNT_TOP_MIN - 9'h001));                // RULE11
         pulse_ff.top_level <= lvl_top;
      end
   end

   assign pulse_o = pulse_ff;

   a_mid_min_width : assert property (@(posedge clk_sys_i) disable iff (!nrst_i)      // RULE3
      pulse_ff.mid_done |-> $past(act_cnt_ff) >= CNT_MID_MIN)
      else $error("mid pulse accepted below least width");

endmodule // pfp_pulse_classifier

// File: hw/pfp_fuse_prog.sv
`timescale 1ns/10ps
// Function
// RULE1 - Pin levels are classed low, middle or top from two comparators.
// RULE2 - Programmer holds top pulses at least 30 us, rests 30 us after.
// RULE3 - Programmer holds middle pulses at least 15 us, rests 5 us after.
// RULE4 - Select: top pulse, key count of middle pulses, top pulse, no power loss.
// RULE5 - Key 1 zero-field trim, key 2 gain, key 3 drift, invert and seal.
// RULE6 - Keys and codes count in binary, bit 0 worth one.
// RULE7 - Closing top pulse of selection enters bit field addressing.
// RULE8 - Each middle pulse falling edge adds one to the code, saturating.
// RULE9 - The addressed code drives the trim outputs at once.
// RULE10 - Power cycle returns every unblown location to zero.
// RULE11 - Top pulse of 30 us while addressing burns the addressed fuse.
// RULE12 - Programmer burns one bit per pass, power cycling in between.
// RULE13 - Field value is independent of burn order.
// RULE14 - Burnt bits stay; later bits add as a union until sealed.
// RULE15 - A burnt seal fuse refuses all further programming.
// RULE16 - Programmer waits the low delay after a burn before power off.
// RULE17 - Programmer order: invert, drift, gain, zero-field, seal last.
// RULE18 - After power-up middle pulses are ignored until a top pulse.
// RULE19 - Gain and zero-field 0..63; drift 0..7, invert code 8, seal 16.
// RULE20 - Programmer cycles power after every burn before more programming.
// RULE21 - An unknown key selects nothing until the next power cycle.
// RULE22 - Top pulse while addressing burns, then idles until power cycle.
module pfp_fuse_prog
(
   input  wire logic                       clk_sys_i,
   input  wire logic                       nrst_i,
   input  wire logic                       mid_cmp_i,
   input  wire logic                       top_cmp_i,
   input  wire logic [pfp_pkg::FUSE_W-1:0] fuse_sense_i,
   input  wire logic                       wb_cyc_i,
   input  wire logic                       wb_stb_i,
   input  wire logic                       wb_we_i,
   input  wire logic [pfp_pkg::ADR_W-1:0]  wb_adr_i,
   input  wire logic [3:0]                 wb_sel_i,
   input  wire logic [31:0]                wb_dat_i,
   output logic      [31:0]                wb_dat_o,
   output logic                            wb_ack_o,
   output pfp_pkg::pfp_trim_type           trim_o,
   output logic                            burn_en_o,
   output logic      [pfp_pkg::FUSE_W-1:0] burn_mask_o
);
   import pfp_pkg::*;

   pfp_pulse_type          pulse;
   pfp_state_type          state_ff;
   logic [KEY_W-1:0]       key_ff;
   logic [CODE_W-1:0]      code_ff;
   logic [FUSE_W-1:0]      fuse_s1_ff;
   logic [FUSE_W-1:0]      fuse_ff;
   pfp_trim_type           trim_ff;
   pfp_trim_type           nxt_trim;
   logic                   burn_en_ff;
   logic [FUSE_W-1:0]      burn_mask_ff;
   logic [31:0]            ctrl_ff;
   logic [31:0]            rdat_ff;
   logic                   ack_ff;
   logic                   enable;
   logic                   sealed;
   logic                   ev_mid;
   logic                   ev_top;
   logic                   ev_qual;
   logic                   try_on;
   logic                   bus_req;
   logic [31:0]            rd_value;

   ////////////////////////////////////////////////////////////////////////////
   // Decoding shared by the state machine, counter and burn logic

   // Highest code of each field
   function automatic logic [CODE_W-1:0] max_code(input logic [KEY_W-1:0] key);
      unique case (key)
         KEY_ZERO_FIELD : max_code = ZERO_FIELD_MAX;   // RULE19
         KEY_GAIN       : max_code = GAIN_MAX;         // RULE19
         KEY_MISC       : max_code = MISC_MAX;         // RULE19
         default        : max_code = 6'h00;
      endcase
   endfunction

   // Only three keys name a register
   function automatic logic key_valid(input logic [KEY_W-1:0] key);
      key_valid = (key == KEY_ZERO_FIELD) || (key == KEY_GAIN) || (key == KEY_MISC);  // RULE5
   endfunction

   // Place a code on the fuse positions of its field
   function automatic logic [FUSE_W-1:0] fuse_field(input logic [KEY_W-1:0]  key,
                                                   input logic [CODE_W-1:0] code);
      logic [FUSE_W-1:0] v;
      v = '0;
      unique case (key)
         KEY_ZERO_FIELD : v[FUSE_ZF_LSB +: CODE_W]        = code;                  // RULE5
         KEY_GAIN       : v[FUSE_GAIN_LSB +: CODE_W]      = code;                  // RULE5
         KEY_MISC       : v[FUSE_MISC_LSB +: FUSE_MISC_W] = code[FUSE_MISC_W-1:0]; // RULE5
         default        : v = '0;
      endcase
      fuse_field = v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Pulse decoding on the analog output pin
   pfp_pulse_classifier u_classifier
   (
      .clk_sys_i (clk_sys_i),
      .nrst_i    (nrst_i),
      .mid_cmp_i (mid_cmp_i),
      .top_cmp_i (top_cmp_i),
      .pulse_o   (pulse)
   );

   // Software may mute the pin decoder, e.g. during analog test
   assign enable  = ctrl_ff[CTRL_ENABLE_BIT];
   assign ev_mid  = enable && pulse.mid_done;
   assign ev_top  = enable && pulse.top_done;
   assign ev_qual = enable && pulse.top_qual;

   ////////////////////////////////////////////////////////////////////////////
   // Fuse sense lines settle asynchronously after a burn
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         fuse_s1_ff <= '0;
         fuse_ff    <= '0;
      end
      else
      begin
         fuse_s1_ff <= fuse_sense_i;
         fuse_ff    <= fuse_s1_ff;
      end
   end

   assign sealed = fuse_ff[FUSE_SEAL_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // Programming sequence; reset is the power cycle
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
         state_ff <= ST_INIT;                                        // RULE10
      else
      begin
         unique case (state_ff)
            // Middle pulses do nothing here
            ST_INIT :
               if (ev_top && !sealed)                                // RULE18 RULE15
                  state_ff <= ST_SELECT;
            ST_SELECT :
               if (ev_top)
               begin
                  if (key_valid(key_ff) && !sealed)
                     state_ff <= ST_ADDRESS;                         // RULE7
                  else
                     state_ff <= ST_DONE;                            // RULE21
               end
            ST_ADDRESS :
               if (ev_qual && !sealed)
                  state_ff <= ST_BURN;                               // RULE11
            // Burn lasts as long as the pin stays at top level
            ST_BURN :
               if (!pulse.top_level)
                  state_ff <= ST_DONE;                               // RULE22
            ST_DONE :
               state_ff <= ST_DONE;                                  // RULE22
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Key counter, binary with bit 0 worth one pulse
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
         key_ff <= 3'h0;
      else if ((state_ff == ST_SELECT) && ev_mid && (key_ff != KEY_SAT))
         key_ff <= 3'(key_ff + 3'h1);                                // RULE4 RULE6
   end

   ////////////////////////////////////////////////////////////////////////////
   // Code counter; no way down except a power cycle
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
         code_ff <= 6'h00;                                           // RULE10
      else if ((state_ff == ST_ADDRESS) && ev_mid && (code_ff < max_code(key_ff)))
         code_ff <= 6'(code_ff + 6'h01);                             // RULE8 RULE6
   end

   ////////////////////////////////////////////////////////////////////////////
   // Trim outputs: burnt bits ORed with the tried code
   assign try_on = ((state_ff == ST_ADDRESS) || (state_ff == ST_BURN) || (state_ff == ST_DONE))
                   && key_valid(key_ff);

   always_comb
   begin
      logic [FUSE_W-1:0] eff;
      eff = '0;
      if (try_on)
         eff = fuse_field(key_ff, code_ff);                          // RULE9
      // OR makes the result independent of burn order
      eff = eff | fuse_ff;                                           // RULE13 RULE14
      nxt_trim.zero_field = eff[FUSE_ZF_LSB +: CODE_W];
      nxt_trim.gain       = eff[FUSE_GAIN_LSB +: CODE_W];
      nxt_trim.drift      = eff[FUSE_MISC_LSB +: (MISC_DRIFT_MSB + 1)];
      nxt_trim.invert     = eff[FUSE_MISC_LSB + MISC_INVERT_BIT];
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
         trim_ff <= '0;
      else
         trim_ff <= nxt_trim;                                        // RULE9
   end

   ////////////////////////////////////////////////////////////////////////////
   // Burn drive toward the fuse array, held while the pin is high
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         burn_en_ff   <= 1'b0;
         burn_mask_ff <= '0;
      end
      else if ((state_ff == ST_ADDRESS) && ev_qual && !sealed)       // RULE15
      begin
         burn_en_ff   <= 1'b1;                                       // RULE11
         burn_mask_ff <= fuse_field(key_ff, code_ff);                // RULE11
      end
      else if ((state_ff == ST_BURN) && pulse.top_level)
      begin
         burn_en_ff   <= 1'b1;
         burn_mask_ff <= burn_mask_ff;
      end
      else
      begin
         burn_en_ff   <= 1'b0;
         burn_mask_ff <= '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Wishbone classic slave, one wait state, every address acked
   assign bus_req = wb_cyc_i && wb_stb_i && !ack_ff;

   always_comb
   begin
      rd_value = 32'h0000_0000;
      unique case (wb_adr_i)
         ADR_STATUS :
         begin
            rd_value[ST_STATE_LSB +: 3]      = state_ff;
            rd_value[ST_KEY_LSB +: KEY_W]    = key_ff;
            rd_value[ST_CODE_LSB +: CODE_W]  = code_ff;
            rd_value[ST_SEAL_BIT]            = sealed;
         end
         ADR_TRIM :
         begin
            rd_value[TR_ZF_LSB +: CODE_W]    = trim_ff.zero_field;
            rd_value[TR_GAIN_LSB +: CODE_W]  = trim_ff.gain;
            rd_value[TR_DRIFT_LSB +: 3]      = trim_ff.drift;
            rd_value[TR_INVERT_BIT]          = trim_ff.invert;
         end
         ADR_CTRL : rd_value = ctrl_ff;
         ADR_FUSE : rd_value[FUSE_W-1:0]     = fuse_ff;
         default  : rd_value = 32'h0000_0000;
      endcase
   end

   // Ack pulse and read data
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         ack_ff  <= 1'b0;
         rdat_ff <= 32'h0000_0000;
      end
      else
      begin
         ack_ff  <= bus_req;
         rdat_ff <= bus_req ? rd_value : 32'h0000_0000;
      end
   end

   // Control register; only the enable bit is kept
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
         ctrl_ff <= CTRL_RESET;
      else if (bus_req && wb_we_i && (wb_adr_i == ADR_CTRL) && wb_sel_i[0])
         ctrl_ff <= {31'h0000_0000, wb_dat_i[CTRL_ENABLE_BIT]};
   end

   assign wb_ack_o    = ack_ff;
   assign wb_dat_o    = rdat_ff;
   assign trim_o      = trim_ff;
   assign burn_en_o   = burn_en_ff;
   assign burn_mask_o = burn_mask_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   a_init_ignores_mid : assert property (@(posedge clk_sys_i) disable iff (!nrst_i)   // RULE18
      (state_ff == ST_INIT) && !ev_top |=> (state_ff == ST_INIT))
      else $error("left initial state without a top pulse");

   a_select_enters_addr : assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RULE7
      (state_ff == ST_SELECT) && ev_top && key_valid(key_ff) && !sealed |=> (state_ff == ST_ADDRESS))
      else $error("valid key did not enter addressing");

   a_bad_key_dead : assert property (@(posedge clk_sys_i) disable iff (!nrst_i)       // RULE21
      (state_ff == ST_SELECT) && ev_top && !key_valid(key_ff) |=> (state_ff == ST_DONE) [*4])
      else $error("unknown key did not leave logic idle");

   a_code_increments : assert property (@(posedge clk_sys_i) disable iff (!nrst_i)    // RULE8
      (state_ff == ST_ADDRESS) && ev_mid && (code_ff < max_code(key_ff))
      |=> code_ff == 6'($past(code_ff) + 6'h01))
      else $error("code did not step by one");

   a_code_saturates : assert property (@(posedge clk_sys_i) disable iff (!nrst_i)     // RULE8
      (state_ff == ST_ADDRESS) |-> (code_ff <= max_code(key_ff)))
      else $error("code passed field maximum");

   a_try_drives_gain : assert property (@(posedge clk_sys_i) disable iff (!nrst_i)    // RULE9
      (state_ff == ST_ADDRESS) && (key_ff == KEY_GAIN)
      |=> trim_o.gain == ($past(code_ff) | $past(fuse_ff[FUSE_GAIN_LSB +: CODE_W])))
      else $error("tried gain code not on trim output");

   a_burn_on_top : assert property (@(posedge clk_sys_i) disable iff (!nrst_i)        // RULE11
      (state_ff == ST_ADDRESS) && ev_qual && !sealed
      |=> burn_en_o && (burn_mask_o == fuse_field($past(key_ff), $past(code_ff))) && (state_ff == ST_BURN))
      else $error("blow pulse did not burn addressed bits");

   a_burn_only_burning : assert property (@(posedge clk_sys_i) disable iff (!nrst_i)  // RULE22
      burn_en_o |-> (state_ff == ST_BURN) || ($past(state_ff) == ST_BURN))
      else $error("burn drive outside burn state");

   a_fuse_bits_kept : assert property (@(posedge clk_sys_i) disable iff (!nrst_i)     // RULE14
      1'b1 |=> (trim_o.zero_field & $past(fuse_ff[FUSE_ZF_LSB +: CODE_W]))
               == $past(fuse_ff[FUSE_ZF_LSB +: CODE_W]))
      else $error("burnt zero-field bit lost");

   a_seal_refuses : assert property (@(posedge clk_sys_i) disable iff (!nrst_i)       // RULE15
      sealed && (state_ff == ST_INIT) |=> (state_ff == ST_INIT) && !burn_en_o)
      else $error("programming accepted after seal");

   a_ack_single : assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

endmodule // pfp_fuse_prog

// File: sim/pfp_prog_model.sv
`timescale 1ns/10ps
// Pulse supply on the pin plus the external fuse array
module pfp_prog_model
(
   input  wire logic        clk_sys_i,
   input  wire logic        burn_en_i,
   input  wire logic [16:0] burn_mask_i,
   output logic             mid_cmp_o,
   output logic             top_cmp_o,
   output logic [16:0]      fuse_sense_o
);
   logic [16:0] seen_ff;
   initial
   begin
      mid_cmp_o = 1'b0;
      top_cmp_o = 1'b0;
      fuse_sense_o = 17'h0;
      seen_ff = 17'h0;
   end
   // Fuses only ever set; a power cycle of the device leaves them alone
   always @(posedge clk_sys_i)
   begin
      if (burn_en_i)
      begin
         fuse_sense_o <= fuse_sense_o | burn_mask_i;
         seen_ff <= seen_ff | burn_mask_i;
      end
   end
   // Top level also trips the middle comparator; pin rests low afterwards
   task automatic pulse(input logic top, input int width, input int rest);
      @(posedge clk_sys_i);
      mid_cmp_o <= 1'b1;
      top_cmp_o <= top;
      repeat (width) @(posedge clk_sys_i);
      mid_cmp_o <= 1'b0;
      top_cmp_o <= 1'b0;
      repeat (rest) @(posedge clk_sys_i);
   endtask
   task automatic clear_seen();
      seen_ff = 17'h0;
   endtask
endmodule // pfp_prog_model

// File: sim/testbench.sv
`timescale 1ns/10ps
module testbench;
   import pfp_pkg::*;
   logic          clk_sys_i, nrst_i, mid_cmp, top_cmp, burn_en_o;
   logic          wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0]    wb_adr_i;
   logic [3:0]    wb_sel_i;
   logic [31:0]   wb_dat_i, wb_dat_o, rd;
   logic [16:0]   fuse, burn_mask_o;
   pfp_trim_type  trim_o;
   int            errors, num_checks;
   pfp_fuse_prog u_pfp_fuse_prog (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .mid_cmp_i(mid_cmp),
      .top_cmp_i(top_cmp), .fuse_sense_i(fuse), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .trim_o(trim_o), .burn_en_o(burn_en_o),
      .burn_mask_o(burn_mask_o));
   pfp_prog_model u_pfp_prog_model (.clk_sys_i(clk_sys_i), .burn_en_i(burn_en_o),
      .burn_mask_i(burn_mask_o), .mid_cmp_o(mid_cmp), .top_cmp_o(top_cmp), .fuse_sense_o(fuse));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      if (errors == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Classic single cycle; bounded wait so a dead slave cannot hang the run
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'hf;
      wb_dat_i <= d;
      do
      begin
         @(posedge clk_sys_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         errors++;
         print_verdict();
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask
   // Power cycle: fuses survive, wait out the sense synchroniser
   task automatic pc();
      nrst_i <= 1'b0;
      repeat (5) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      repeat (6) @(posedge clk_sys_i);
   endtask
   task automatic mids(input int n);
      repeat (n) u_pfp_prog_model.pulse(1'b0, 160, 60);
   endtask
   task automatic top();
      u_pfp_prog_model.clear_seen();
      u_pfp_prog_model.pulse(1'b1, 320, 310);
   endtask
   task automatic sel(input int k);
      top();
      mids(k);
      top();
   endtask
   function automatic logic [31:0] tr(input int zf, input int g, input int d, input int i);
      return {16'h0, 6'(zf), 6'(g), 3'(d), 1'(i)};
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   task automatic s_try();
      mids(2);
      sel(1);
      mids(5);
      chk({16'h0, trim_o}, tr(5, 0, 0, 0));
      wb(1'b0, ADR_STATUS, 32'h0);
      chk(rd, 32'h0000_0512);
      pc();
      chk({16'h0, trim_o}, tr(0, 0, 0, 0));
   endtask
   task automatic s_sat();
      sel(2);
      mids(64);
      chk({16'h0, trim_o}, tr(0, 63, 0, 0));
      pc();
      sel(3);
      mids(5);
      chk({16'h0, trim_o}, tr(0, 0, 5, 0));
      mids(3);
      chk({16'h0, trim_o}, tr(0, 0, 0, 1));
      mids(9);
      wb(1'b0, ADR_STATUS, 32'h0);
      chk(rd, 32'h0000_1032);
      pc();
   endtask
   // Code 5 burnt as 4 then 1, with a power cycle between
   task automatic s_blow();
      sel(1);
      mids(4);
      top();
      chk(32'(u_pfp_prog_model.seen_ff), 32'h4);
      mids(1);
      chk({16'h0, trim_o}, tr(4, 0, 0, 0));
      pc();
      sel(1);
      mids(1);
      top();
      pc();
      chk({16'h0, trim_o}, tr(5, 0, 0, 0));
      wb(1'b0, ADR_FUSE, 32'h0);
      chk(rd, 32'h5);
      sel(4);
      mids(3);
      top();
      chk({16'h0, trim_o} | 32'(u_pfp_prog_model.seen_ff), tr(5, 0, 0, 0));
      pc();
   endtask
   task automatic s_reg();
      wb(1'b1, ADR_CTRL, 32'h0);
      sel(1);
      mids(2);
      chk({16'h0, trim_o}, tr(5, 0, 0, 0));
      wb(1'b0, ADR_CTRL, 32'h0);
      chk(rd, 32'h0);
      wb(1'b1, ADR_CTRL, 32'h1);
      wb(1'b0, 8'h40, 32'h0);
      chk(rd, 32'h0);
      pc();
   endtask
   task automatic s_seal();
      sel(3);
      mids(16);
      top();
      chk(32'(u_pfp_prog_model.seen_ff), 32'h1_0000);
      pc();
      sel(1);
      mids(2);
      top();
      chk({16'h0, trim_o} | 32'(u_pfp_prog_model.seen_ff), tr(5, 0, 0, 0));
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Clock, reset, then the scenarios in order
   initial
   begin
      clk_sys_i = 1'b0;
      forever #50 clk_sys_i = ~clk_sys_i;
   end
   initial
   begin
      {nrst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
      errors = 0;
      num_checks = 0;
      repeat (5) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      repeat (6) @(posedge clk_sys_i);
      s_try();
      s_sat();
      s_blow();
      s_reg();
      s_seal();
      print_verdict();
   end
endmodule // testbench
